// ===== design/tmt_pkg.sv
// constants and carrier types for the timing/mark track logic
// assumes a 50 MHz system clock and an AXI4-Lite register master
//
// Function
// RULE1 - track writing needs timing-mark function code and relay level asserted
// RULE2 - timing-mark mode runs from 8.33 us local clock, only while relay asserted
// RULE3 - each local tick advances phase counter and copies its bit to track buffer
// RULE4 - counter bit toggles both ways only when enabled, else only forced to zero
// RULE5 - toggling allowed by write switch, or full-speed motion in timing-mark mode
// RULE6 - track write buffer changes every 16.6 us, quarter period behind counter bit
// RULE7 - left pulse when counter bit rises, right pulse when it falls
// RULE8 - left pulse centres left polarization, right pulse centres right polarization
// RULE9 - left pulse loads mark buffer and data bit 0 from shift top; right inverts
// RULE10 - read pulses from direction-selected amplifier output, left/right on phase falls; code gives left on the rise, right on the fall
// RULE11 - each recovered pulse drops the pulse gate for 10 us
// RULE12 - relay level forces the timing pulse gate off
// RULE13 - otherwise gate asserts once motion is on and start/speed delay expired
// RULE14 - while writing, write permit flag keeps pulses gated on until cleared
// RULE15 - each right pulse shifts mark read level into window lsb
// RULE16 - block mark decode when low eight window bits are octal 126
// RULE17 - guard mark decode when low eight window bits are octal 351
// RULE18 - reverse motion shifts the complemented forward mark data, reversed order
// RULE19 - marks span six left pulses; decode holds right pulse before to after
// RULE20 - all-bits mode for read-all, write-all and timing-mark functions
// RULE21 - while writing tracks, right pulses are blocked and window stays clear; code still emits right pulses, only the window shift is blocked
// RULE22 - read/write-all keep window, transfer continuously, no parity, overwrite numbers
// RULE23 - all-bits mode transfers one word per four tape lines while moving
// RULE24 - each timing pulse is a single-cycle strobe from a synchronized edge
package tmt_pkg;
  localparam int          CLK_NS          = 20;
  localparam real         LOCAL_CLK_US    = 8.33;
  localparam int          LOCAL_CLK_CYC   = int'(LOCAL_CLK_US * 1000.0) / CLK_NS;
  localparam int          LOCKOUT_US      = 10;
  localparam int          LOCKOUT_CYC     = LOCKOUT_US * 1000 / CLK_NS;
  localparam int          CNT_W           = 10;
  localparam int          WIN_W           = 18;
  localparam logic [7:0]  MARK_BLOCK      = 8'o126;
  localparam logic [7:0]  MARK_GUARD      = 8'o351;
  localparam int          LINES_PER_WORD  = 4;
  localparam logic [31:0] OFF_CTRL        = 32'h0000_0000;
  localparam logic [31:0] OFF_STATUS      = 32'h0000_0004;
  localparam int          CTRL_FUNC_LSB   = 0;
  localparam int          CTRL_REV_BIT    = 3;
  localparam int          CTRL_GO_BIT     = 4;
  localparam logic [4:0]  CTRL_RESET      = 5'h0_0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    TMT_FN_MOVE, TMT_FN_SEARCH, TMT_FN_READ, TMT_FN_READ_ALL,
    TMT_FN_WRITE, TMT_FN_WRITE_ALL, TMT_FN_TIMING_MARK, TMT_FN_SPARE
  } tmt_func_t;

  // amplifier, relay and write switch levels from the transport, asynchronous to clk_sys_i
  typedef struct packed {
    logic timing_read_z;
    logic timing_read_y;
    logic mark_read_level;
    logic timing_write_relay_level;
    logic timing_write_switch;
  } tmt_pins_t;

  // write-side levels toward the heads
  typedef struct packed {
    logic timing_track_write_buffer;
    logic mark_write_buffer;
    logic data_write_bit0;
  } tmt_wr_t;
endpackage : tmt_pkg

// ===== design/tmt_track_logic.sv
// timing-track generation/recovery, mark window and all-bits decode
// assumes pins are asynchronous, other inputs share clk_sys_i
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tmt_track_logic (
  input  wire logic              clk_sys_i,        // 50 MHz clock
  input  wire logic              reset_i,          // async reset, high
  input  wire logic              ce_i,             // clock enable
  input  wire tmt_pkg::tmt_pins_t pins_i,          // amplifier, relay and switch levels
  input  wire logic              speed_delay_done_i, // start/speed delay expired
  input  wire logic              write_permit_flag_i, // write enable flag
  input  wire logic              shift_top_bit_i,  // shift buffer top bit
  output tmt_pkg::tmt_wr_t       wr_o,             // write buffers
  output logic                   left_timing_pulse_o,  // strobe
  output logic                   right_timing_pulse_o, // strobe
  output logic                   shift_strobe_o,   // shift buffer shift
  output logic                   word_xfer_o,      // word transfer strobe
  output logic                   timing_pulse_gate_o, // gate level
  output logic                   block_mark_decode_o, // block mark
  output logic                   guard_mark_decode_o, // guard mark
  output logic                   all_bits_mode_o,  // all-bits mode
  output logic                   parity_check_en_o, // parity checking on
  output logic                   block_overwrite_o, // block numbers overwritten
  input  wire logic [31:0]       s_axi_awaddr,     // write address
  input  wire logic              s_axi_awvalid,    // write address valid
  output logic                   s_axi_awready,    // write address ready
  input  wire logic [31:0]       s_axi_wdata,      // write data
  input  wire logic [3:0]        s_axi_wstrb,      // byte enables
  input  wire logic              s_axi_wvalid,     // write data valid
  output logic                   s_axi_wready,     // write data ready
  output logic [1:0]             s_axi_bresp,      // write response
  output logic                   s_axi_bvalid,     // response valid
  input  wire logic              s_axi_bready,     // response ready
  input  wire logic [31:0]       s_axi_araddr,     // read address
  input  wire logic              s_axi_arvalid,    // read address valid
  output logic                   s_axi_arready,    // read address ready
  output logic [31:0]            s_axi_rdata,      // read data
  output logic [1:0]             s_axi_rresp,      // read response
  output logic                   s_axi_rvalid,     // read valid
  input  wire logic              s_axi_rready      // read ready
);
  import tmt_pkg::*;

  // ---------------- synchronisers ----------------
  tmt_pins_t pins_m_reg, pins_s_reg;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pins_m_reg <= '0;
      pins_s_reg <= '0;
    end else if (ce_i) begin
      pins_m_reg <= pins_i;
      pins_s_reg <= pins_m_reg;
    end
  end

  // ---------------- register bus ----------------
  logic [4:0]  ctrl_reg, ctrl_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr_take, rd_take;
  logic [31:0] status_word;

  assign wr_take = ce_i & s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign rd_take = ce_i & s_axi_arvalid & ~rvalid_reg;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_comb begin
    ctrl_next   = ctrl_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (wr_take) begin
      bvalid_next = 1'b1;
      bresp_next  = RESP_SLVERR;
      if (s_axi_awaddr[7:2] == OFF_CTRL[7:2] && s_axi_awaddr[31:8] == 24'h00_0000) begin
        bresp_next = RESP_OKAY;
        if (s_axi_wstrb[0])
          ctrl_next = s_axi_wdata[4:0];
      end else if (s_axi_awaddr == OFF_STATUS) begin
        bresp_next = RESP_OKAY;
      end
    end
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      if (s_axi_araddr == OFF_CTRL)
        rdata_next = {27'h000_0000, ctrl_reg};
      else if (s_axi_araddr == OFF_STATUS)
        rdata_next = status_word;
      else begin
        rdata_next = 32'h0000_0000;
        rresp_next = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg   <= CTRL_RESET;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (ce_i) begin
      ctrl_reg   <= ctrl_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ---------------- mode decode ----------------
  tmt_func_t func;
  logic reverse, go, relay, up_to_speed, timing_mark_fn, track_write_en;
  logic write_fn, toggle_en;
  assign func           = tmt_func_t'(ctrl_reg[CTRL_FUNC_LSB +: 3]);
  assign reverse        = ctrl_reg[CTRL_REV_BIT];
  assign go             = ctrl_reg[CTRL_GO_BIT];
  assign relay          = pins_s_reg.timing_write_relay_level;
  assign up_to_speed    = go & speed_delay_done_i;
  assign timing_mark_fn = (func == TMT_FN_TIMING_MARK);
  assign track_write_en = timing_mark_fn & relay;                 // RULE1
  assign write_fn       = (func == TMT_FN_WRITE) | (func == TMT_FN_WRITE_ALL);
  assign toggle_en      = pins_s_reg.timing_write_switch |
                          (up_to_speed & timing_mark_fn);          // RULE5
  assign all_bits_mode_o   = (func == TMT_FN_READ_ALL) |
                             (func == TMT_FN_WRITE_ALL) |
                             timing_mark_fn;                       // RULE20
  assign parity_check_en_o = ~all_bits_mode_o;                     // RULE22
  assign block_overwrite_o = all_bits_mode_o & write_fn;          // RULE22

  // ---------------- core state ----------------
  logic [CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic [CNT_W-1:0] lock_cnt_reg, lock_cnt_next;
  logic             phase_bit_reg, phase_bit_next;
  logic             phase_bit_d_reg, phase_bit_d_next;
  logic             phase_half_reg, phase_half_next;
  logic             tt_d_reg, tt_d_next;
  logic [WIN_W-1:0] win_reg, win_next;
  logic [1:0]       line_cnt_reg, line_cnt_next;
  tmt_wr_t          wr_reg, wr_next;
  logic             tick, tt_sel, gen_left, gen_right, rd_left, rd_right;
  logic             gate, left_p, right_p;

  assign tick      = relay & (tick_cnt_reg == '0);                // RULE2
  assign gen_left  = phase_bit_reg & ~phase_bit_d_reg;            // RULE7
  assign gen_right = ~phase_bit_reg & phase_bit_d_reg;            // RULE7
  // direction picks the amplifier output feeding the high phase
  assign tt_sel    = reverse ? pins_s_reg.timing_read_y
                             : pins_s_reg.timing_read_z;          // RULE10
  assign rd_left   = tt_sel & ~tt_d_reg;                          // RULE10
  assign rd_right  = ~tt_sel & tt_d_reg;                          // RULE10
  assign gate      = ~relay & (lock_cnt_reg == '0) &
                     (up_to_speed | (write_fn & write_permit_flag_i)); // RULE12 RULE13 RULE14
  assign left_p    = ce_i & (relay ? gen_left  : (gate & rd_left));  // RULE24 RULE8
  assign right_p   = ce_i & (relay ? gen_right : (gate & rd_right)); // RULE24 RULE8

  always_comb begin
    tick_cnt_next = tick_cnt_reg;
    lock_cnt_next = lock_cnt_reg;
    phase_bit_next   = phase_bit_reg;
    phase_bit_d_next = phase_bit_reg;
    phase_half_next  = phase_half_reg;
    tt_d_next     = tt_sel;
    win_next      = win_reg;
    line_cnt_next = line_cnt_reg;
    wr_next       = wr_reg;
    // local clock divider, stopped while the relay is off
    if (!relay)
      tick_cnt_next = CNT_W'(LOCAL_CLK_CYC - 1);
    else if (tick)
      tick_cnt_next = CNT_W'(LOCAL_CLK_CYC - 1);                  // RULE2
    else
      tick_cnt_next = tick_cnt_reg - 1'b1;
    if (tick) begin
      wr_next.timing_track_write_buffer = phase_bit_reg;          // RULE3 RULE6
      phase_half_next = ~phase_half_reg;                          // RULE3
      // toggle bit moves on every second local clock
      if (phase_half_reg && toggle_en)
        phase_bit_next = ~phase_bit_reg;                          // RULE4 RULE6
      else if (phase_half_reg)
        phase_bit_next = 1'b0;                                    // RULE4
    end
    // cross-talk lockout after each recovered pulse
    if (!relay && gate && (rd_left || rd_right))
      lock_cnt_next = CNT_W'(LOCKOUT_CYC - 1);                    // RULE11
    else if (lock_cnt_reg != '0)
      lock_cnt_next = lock_cnt_reg - 1'b1;
    // mark track and data bit 0 writing
    if (track_write_en && left_p) begin
      wr_next.mark_write_buffer = shift_top_bit_i;                // RULE9
      wr_next.data_write_bit0   = shift_top_bit_i;                // RULE9
    end else if (track_write_en && right_p) begin
      wr_next.mark_write_buffer = ~wr_reg.mark_write_buffer;      // RULE9
      wr_next.data_write_bit0   = ~wr_reg.data_write_bit0;        // RULE9
    end
    // window; the amplifier itself inverts the level in reverse
    if (relay)
      win_next = '0;                                              // RULE21
    else if (right_p)
      win_next = {win_reg[WIN_W-2:0], pins_s_reg.mark_read_level}; // RULE15 RULE18
    // word pacing in all-bits mode
    if (!(all_bits_mode_o && go))
      line_cnt_next = 2'h0;
    else if (right_p)
      line_cnt_next = line_cnt_reg + 1'b1;                        // RULE23
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_reg <= '0;
      lock_cnt_reg <= '0;
      phase_bit_reg   <= 1'b0;
      phase_bit_d_reg <= 1'b0;
      phase_half_reg  <= 1'b0;
      tt_d_reg     <= 1'b0;
      win_reg      <= '0;
      line_cnt_reg <= 2'h0;
      wr_reg       <= '0;
    end else if (ce_i) begin
      tick_cnt_reg <= tick_cnt_next;
      lock_cnt_reg <= lock_cnt_next;
      phase_bit_reg   <= phase_bit_next;
      phase_bit_d_reg <= phase_bit_d_next;
      phase_half_reg  <= phase_half_next;
      tt_d_reg     <= tt_d_next;
      win_reg      <= win_next;
      line_cnt_reg <= line_cnt_next;
      wr_reg       <= wr_next;
    end
  end

  assign wr_o                 = wr_reg;
  assign left_timing_pulse_o  = left_p;
  assign right_timing_pulse_o = right_p;
  assign shift_strobe_o       = track_write_en & left_p;          // RULE9
  assign word_xfer_o          = all_bits_mode_o & go & right_p &
                                (line_cnt_reg == 2'(LINES_PER_WORD - 1)); // RULE23 RULE22
  assign timing_pulse_gate_o  = gate;
  // decodes hold from the right pulse before to the one after a mark
  assign block_mark_decode_o  = (win_reg[7:0] == MARK_BLOCK);     // RULE16 RULE19
  assign guard_mark_decode_o  = (win_reg[7:0] == MARK_GUARD);     // RULE17 RULE19
  assign status_word = {6'h00, gate, all_bits_mode_o, guard_mark_decode_o,
                        block_mark_decode_o, phase_bit_reg, wr_reg, win_reg};

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_relay_gate_off: assert property (relay |-> !timing_pulse_gate_o) // RULE12
    else $error("gate open while relay level asserted");
  a_lockout_holds: assert property (
    (ce_i && !relay && gate && (rd_left || rd_right)) |=>
      (lock_cnt_reg == CNT_W'(LOCKOUT_CYC - 1)) && !timing_pulse_gate_o) // RULE11
    else $error("lockout not started by recovered pulse");
  a_lockout_span: assert property (
    (ce_i && lock_cnt_reg > 10'd8) |=> !timing_pulse_gate_o [*8]) // RULE11
    else $error("gate reopened during lockout");
  a_left_on_rise: assert property ( // RULE7
    (ce_i && relay && phase_bit_reg && !phase_bit_d_reg) |->
      left_timing_pulse_o)
    else $error("no left pulse on counter rise");
  a_track_buf_follows: assert property ( // RULE3
    (ce_i && tick) |=>
      wr_o.timing_track_write_buffer == $past(phase_bit_reg))
    else $error("track buffer did not copy counter bit");
  a_toggle_zero_only: assert property ( // RULE4
    (ce_i && tick && phase_half_reg && !toggle_en) |=> !phase_bit_reg)
    else $error("counter bit toggled while disabled");
  a_tick_period: assert property (
    (ce_i && tick) |=> (tick_cnt_reg == CNT_W'(LOCAL_CLK_CYC - 1))) // RULE2
    else $error("local clock period wrong");
  a_block_decode: assert property (
    (win_reg[7:0] == 8'o126) |-> block_mark_decode_o && !guard_mark_decode_o) // RULE16
    else $error("block mark not decoded");
  a_guard_decode: assert property (
    (win_reg[7:0] == 8'o351) |-> guard_mark_decode_o) // RULE17
    else $error("guard mark not decoded");
  a_window_clear: assert property ((ce_i && relay) |=> win_reg == '0) // RULE21
    else $error("window not cleared in track write");
  a_window_shift: assert property (
    (ce_i && !relay && right_p) |=>
      win_reg[0] == $past(pins_s_reg.mark_read_level)) // RULE15
    else $error("mark level not shifted into window");
  a_mark_load: assert property (
    (track_write_en && left_p) |=>
      wr_o.mark_write_buffer == $past(shift_top_bit_i)) // RULE9
    else $error("mark buffer not loaded on left pulse");
  a_pulse_single: assert property (left_timing_pulse_o |=> !left_timing_pulse_o) // RULE24
    else $error("left pulse longer than one cycle");
  a_all_bits: assert property (
    (func == TMT_FN_READ_ALL || func == TMT_FN_WRITE_ALL) |-> all_bits_mode_o) // RULE20
    else $error("all-bits mode not set");
endmodule : tmt_track_logic
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the timing/mark track logic
// assumes the tape model on the amplifier pins and an axi-lite master here
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmt_pkg::*;
  localparam logic [15:0] TRACK_BITS = 16'h6856;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        link_clk  = 1'b0;
  logic        relay = 1'b0, sw = 1'b0, dly = 1'b0, permit = 1'b0;
  logic        top = 1'b0, start = 1'b0, rev = 1'b0, ce = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        tz, ty, mk, busy, lp, rp, ss, wx, gate, bmk, gmk, allb;
  logic        par, ovw;
  tmt_wr_t     wr;
  tmt_pins_t   pins;
  int          bad_count = 0, checks_done = 0, lc = 0, rc = 0, wc = 0;

  assign pins = {tz, ty, mk, relay, sw};
  always #10 clk_sys_i = ~clk_sys_i;
  initial begin
    #3;
    forever #80 link_clk = ~link_clk;
  end
  always @(posedge clk_sys_i) begin
    if (lp) lc++;
    if (rp) rc++;
    if (wx) wc++;
  end

  tmt_track_logic i_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce), .pins_i(pins),
    .speed_delay_done_i(dly), .write_permit_flag_i(permit),
    .shift_top_bit_i(top), .wr_o(wr), .left_timing_pulse_o(lp),
    .right_timing_pulse_o(rp), .shift_strobe_o(ss), .word_xfer_o(wx),
    .timing_pulse_gate_o(gate), .block_mark_decode_o(bmk),
    .guard_mark_decode_o(gmk), .all_bits_mode_o(allb),
    .parity_check_en_o(par), .block_overwrite_o(ovw),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  tmt_tape_model i_tape (
    .link_clk_i(link_clk), .start_i(start), .reverse_i(rev),
    .track_bits_i(TRACK_BITS), .timing_z_o(tz), .timing_y_o(ty),
    .mark_o(mk), .busy_o(busy));

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task expire;
    $display("[FAIL] t=%0t wait limit reached", $time);
    bad_count++;
    test_done();
  endtask : expire

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task axi_wr(input logic [31:0] a, input logic [31:0] d,
              input logic [1:0] er);
    int   n;
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk_sys_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge clk_sys_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
      if (n > 50) expire();
    end while (!tb);
    bready <= 1'b0;
    chk(r, er);
  endtask : axi_wr

  task axi_rd(input logic [31:0] a, output logic [31:0] d,
              output logic [1:0] r);
    int   n;
    logic ta, tr;
    @(posedge clk_sys_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk_sys_i);
      if (ta) arvalid <= 1'b0;
      n++;
      if (n > 50) expire();
    end while (!tr);
    rready <= 1'b0;
  endtask : axi_rd

  task settle(input int k);
    repeat (k) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : settle

  task wait_pulse(input logic right, output int n);
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
      if (n > 2000) expire();
    end while (!(right ? rp : lp));
  endtask : wait_pulse

  task run_tape;
    int n;
    @(posedge clk_sys_i);
    start <= 1'b1;
    n = 0;
    while (!busy) begin
      @(posedge clk_sys_i);
      n++;
      if (n > 100) expire();
    end
    start <= 1'b0;
    wait_pulse(1'b0, n);
    settle(0);
    chk(gate, 1'b0);
    settle(498);
    chk(gate, 1'b0);
    settle(0);
    chk(gate, 1'b1);
    while (busy) begin
      @(posedge clk_sys_i);
      n++;
      if (n > 40000) expire();
    end
    settle(20);
  endtask : run_tape

  function automatic logic [7:0] exp_win(input logic [15:0] p,
                                         input logic r);
    logic [7:0] w;
    for (int i = 0; i < 8; i++) w[i] = r ? ~p[15 - i] : p[i];
    return w;
  endfunction : exp_win

  initial begin
    #2_000_000;
    expire();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n, l0, r0, w0;
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    settle(1);
    chk(par, 1'b1);
    chk(gate, 1'b0);
    axi_rd(OFF_CTRL, d, r);
    chk(d, 32'h0000_0000);
    axi_rd(32'h0000_0010, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0000_0000);
    axi_wr(32'h0000_0010, 32'h0000_0001, RESP_SLVERR);
    for (int f = 0; f < 8; f++) begin
      axi_wr(OFF_CTRL, 32'(f), RESP_OKAY);
      axi_rd(OFF_CTRL, d, r);
      chk(d, 32'(f));
      chk(allb, f == 3 || f == 5 || f == 6);
      chk(ovw, f == 5);
      if (f == 2 || f == 3) chk(par, f == 2);
    end
    axi_wr(OFF_CTRL, 32'h0000_0012, RESP_OKAY);
    settle(3);
    chk(gate, 1'b0);
    @(posedge clk_sys_i);
    dly <= 1'b1;
    settle(3);
    chk(gate, 1'b1);
    @(posedge clk_sys_i);
    dly    <= 1'b0;
    permit <= 1'b1;
    axi_wr(OFF_CTRL, 32'h0000_0014, RESP_OKAY);
    settle(3);
    chk(gate, 1'b1);
    @(posedge clk_sys_i);
    permit <= 1'b0;
    settle(3);
    chk(gate, 1'b0);
    @(posedge clk_sys_i);
    dly <= 1'b1;
    // forward read-all, then reverse read
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys_i);
      rev <= k[0];
      axi_wr(OFF_CTRL, k ? 32'h0000_001a : 32'h0000_0013, RESP_OKAY);
      settle(900);
      l0 = lc;
      r0 = rc;
      w0 = wc;
      run_tape();
      chk(lc - l0, 16);
      chk(rc - r0, 16);
      chk(wc - w0, k ? 0 : 4);
      axi_rd(OFF_STATUS, d, r);
      chk(d[7:0], exp_win(TRACK_BITS, k[0]));
      chk(bmk, k == 0);
      chk(gmk, k == 1);
    end
    @(posedge clk_sys_i);
    relay <= 1'b1;
    sw    <= 1'b1;
    top   <= 1'b1;
    axi_wr(OFF_CTRL, 32'h0000_0006, RESP_OKAY);
    wait_pulse(1'b0, n);
    chk(ss, 1'b1);
    chk(wr.timing_track_write_buffer, 1'b0);
    chk(gate, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wait_pulse(1'b1, n);
      chk(n, 2 * LOCAL_CLK_CYC);
      chk(wr.timing_track_write_buffer, 1'b1);
      chk(wr.mark_write_buffer, !k);
      chk(wr.data_write_bit0, !k);
      @(posedge clk_sys_i);
      top <= 1'b0;
      wait_pulse(1'b0, n);
      chk(n, 2 * LOCAL_CLK_CYC);
      chk(wr.timing_track_write_buffer, 1'b0);
      chk(wr.mark_write_buffer, k);
    end
    axi_rd(OFF_STATUS, d, r);
    chk(d[17:0], 18'h0_0000);
    chk(d[25:24], 2'h1);
    @(posedge clk_sys_i);
    sw <= 1'b0;
    settle(900);
    l0 = lc;
    r0 = rc;
    settle(2000);
    chk(lc - l0 + rc - r0, 0);
    axi_wr(OFF_CTRL, 32'h0000_0016, RESP_OKAY);
    wait_pulse(1'b0, n);
    chk(ss, 1'b1);
    // freeze 100 edges: the half period must stretch by exactly that
    @(posedge clk_sys_i);
    ce <= 1'b0;
    settle(99);
    @(posedge clk_sys_i);
    ce <= 1'b1;
    wait_pulse(1'b1, n);
    chk(n, 2 * LOCAL_CLK_CYC);
    settle(415);
    chk(wr.timing_track_write_buffer, 1'b1);
    settle(0);
    chk(wr.timing_track_write_buffer, 1'b0);
    test_done();
  end
endmodule : testbench
`default_nettype wire

// ===== tb/tmt_tape_model.sv
// tape transport model: timing and mark track read amplifiers
// assumes a free-running link time base; one frame of 16 marks per start
`timescale 1ns/1ps
`default_nettype none
module tmt_tape_model (
  input  wire logic        link_clk_i,   // tape time base
  input  wire logic        start_i,      // begin a frame
  input  wire logic        reverse_i,    // tape moves backward
  input  wire logic [15:0] track_bits_i, // mark bits as written forward
  output logic             timing_z_o,   // amplifier output z
  output logic             timing_y_o,   // amplifier output y
  output var logic         mark_o,       // mark amplifier level
  output var logic         busy_o        // frame in progress
);
  logic wave = 1'b0;
  int   idx  = 0;
  int   half = 0;
  // direction picks the amplifier output that carries the wave
  assign timing_z_o = reverse_i ? ~wave : wave;
  assign timing_y_o = reverse_i ? wave : ~wave;
  initial begin
    mark_o = 1'b0;
    busy_o = 1'b0;
  end
  always @(posedge link_clk_i) begin
    if (!busy_o && start_i) begin
      busy_o <= 1'b1;
      idx    <= 0;
      half   <= 0;
    end else if (busy_o) begin
      if (half == 0) begin
        wave   <= 1'b1;
        // backward motion sees complemented bits in reversed order
        mark_o <= reverse_i ? ~track_bits_i[idx]
                            : track_bits_i[15 - idx];
      end
      // mark level held steady across the falling wave edge
      if (half == 104) wave <= 1'b0;
      half <= (half == 207) ? 0 : half + 1;
      if (half == 207) idx <= idx + 1;
      if (half == 207 && idx == 15) busy_o <= 1'b0;
    end
  end
endmodule : tmt_tape_model
`default_nettype wire
